// file: ics_pkg.sv
// Purpose: constants for the instruction cycle sequencer
// Assumes: one system clock, synchronous active high reset
// Notes: phase encoding is gray along the four-phase ring
package ics_pkg;
  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int DATA_AW = 9;
  localparam int DATA_W = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_TOP = 13'h1FFF;
  localparam int CORE_DIV = 4;
  localparam int PLL_MULT = 4;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  typedef enum logic [1:0]
  {
    ICS_PH1 = 2'h0,
    ICS_PH2 = 2'h1,
    ICS_PH3 = 2'h3,
    ICS_PH4 = 2'h2
  } ics_phase_t;
endpackage

// file: ics_clkgen.sv
// Purpose: core clock select and divide-by-four phase generator
// Assumes: pll multiplies the input tick rate; direct uses each tick
// Notes: phases are a two-bit gray-coded state, never overlapping
`timescale 1ns/1ps
`default_nettype none
module ics_clkgen
  import ics_pkg::*;
(
  // system
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration
  input wire logic i_use_pll,
  input wire logic i_clk_tick,
  // core clock and phases
  output logic o_core_tick,
  output ics_pkg::ics_phase_t o_phase,
  output logic o_cycle_out
);
  import ics_pkg::*;
  logic [1:0] pll_cnt;
  logic pll_tick;
  ics_phase_t phase;
  ics_phase_t next_phase;
  logic cyc;
  // pll: emits PLL_MULT core ticks per input tick, held in a counter
  assign pll_tick = i_clk_tick || (pll_cnt != 2'h0);
  assign o_core_tick = i_use_pll ? pll_tick : i_clk_tick;
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      ICS_PH1: next_phase = ICS_PH2;
      ICS_PH2: next_phase = ICS_PH3;
      ICS_PH3: next_phase = ICS_PH4;
      ICS_PH4: next_phase = ICS_PH1;
    endcase
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pll_cnt <= 2'h0;
    else if (i_use_pll && i_clk_tick)
      pll_cnt <= 2'(PLL_MULT - 1);
    else if (pll_cnt != 2'h0)
      pll_cnt <= pll_cnt - 2'h1;
  end
  // divide core clock by four into phases
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      phase <= ICS_PH1;
    else if (o_core_tick)
      phase <= next_phase;
  end
  // cycle rate output high in phases three and four
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cyc <= 1'h0;
    else if (o_core_tick)
      cyc <= (next_phase == ICS_PH3) || (next_phase == ICS_PH4);
  end
  assign o_phase = phase;
  assign o_cycle_out = cyc;
endmodule
`default_nettype wire

// file: ics_sequencer.sv
// Purpose: fetch/execute sequencer of the processor core
// Assumes: program memory answers combinationally to o_prog_addr
// Notes: execute decode beyond jumps is done outside
// Operation
// - core clock comes from pll or straight from clock input
// - core clock divided by four into four non-overlapping phases
// - program counter increments in phase one, starting a fetch
// - addressed instruction word captured during phase four
// - held instruction latched in phase one, executed phases two to four
// - operand read strobe set by the phase two tick, destination write by the phase four tick
// - fetch overlaps execute giving one instruction per cycle
// - program counter changing instructions take two cycles
// - thirteen bit counter over eight k fourteen bit words
// - addresses span lowest to top word of the space
// - reset starts at reset vector, interrupt goes to interrupt vector
// - cycle rate output pin carries core clock over four
`timescale 1ns/1ps
`default_nettype none
module ics_sequencer
  import ics_pkg::*;
#(
  parameter int PW = PC_W,
  parameter int IW = INSN_W
)
(
  // system
  input wire logic i_clk,
  input wire logic i_rst,
  // oscillator
  input wire logic i_use_pll,
  input wire logic i_clk_tick,
  input wire logic i_cycle_out_en,
  output logic o_cycle_out,
  // program memory
  output logic [PW-1:0] o_prog_addr,
  input wire logic [IW-1:0] i_prog_data,
  // execute side
  input wire logic i_jump,
  input wire logic [PW-1:0] i_jump_target,
  input wire logic i_irq,
  output logic [IW-1:0] o_insn,
  output logic o_insn_valid,
  output logic o_operand_read,
  output logic o_dest_write,
  output logic o_irq_taken,
  output logic [1:0] o_phase
);
  import ics_pkg::*;
  logic core_tick;
  ics_phase_t phase;
  logic cyc_raw;
  logic [PW-1:0] pc;
  logic [PW-1:0] next_pc;
  logic [IW-1:0] fetch_word;
  logic [IW-1:0] insn;
  logic flush;
  logic insn_valid;
  logic irq_taken;
  logic operand_rd;
  logic dest_wr;
  logic pc_inc;
  logic [IW-1:0] next_insn;
  logic next_irq_taken;
  logic next_operand_rd;
  logic next_dest_wr;
  logic ph1_tick;
  logic ph2_tick;
  logic ph4_tick;
  logic redirect;
  logic [PW-1:0] redirect_pc;

  ics_clkgen u_clkgen
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_use_pll(i_use_pll),
    .i_clk_tick(i_clk_tick),
    .o_core_tick(core_tick),
    .o_phase(phase),
    .o_cycle_out(cyc_raw)
  );

  assign ph1_tick = core_tick && (phase == ICS_PH1);
  assign ph2_tick = core_tick && (phase == ICS_PH2);
  assign ph4_tick = core_tick && (phase == ICS_PH4);
  // jump or interrupt at end of execute redirects the next fetch
  assign redirect = ph4_tick && insn_valid && (i_jump || i_irq);
  assign redirect_pc = i_irq ? PW'(IRQ_VECTOR) : i_jump_target;
  // hold the counter in the cycle after reset or a redirect, so the
  // vector or target word itself is fetched and not skipped
  assign pc_inc = ph1_tick && !flush;
  assign next_insn = flush ? IW'(NOP_WORD) : fetch_word;
  assign next_irq_taken = redirect && i_irq;
  assign next_operand_rd = ph2_tick && insn_valid;
  assign next_dest_wr = ph4_tick && insn_valid;
  // counter wraps at the top word of the space
  assign next_pc = (pc == PW'(PC_TOP)) ? PW'(RESET_VECTOR)
                                       : pc + PW'(1);

  // program counter
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pc <= PW'(RESET_VECTOR);
    else if (redirect)
      pc <= redirect_pc;
    else if (pc_inc)
      pc <= next_pc;
  end

  // fetch capture in phase four
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fetch_word <= IW'(NOP_WORD);
    else if (ph4_tick)
      fetch_word <= i_prog_data;
  end

  // prefetched word after a redirect is squashed
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      flush <= 1'h1;
    else if (ph4_tick)
      flush <= redirect;
  end

  // instruction holding register, loaded in phase one
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      insn <= IW'(NOP_WORD);
    else if (ph1_tick)
      insn <= next_insn;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      insn_valid <= 1'h0;
    else if (ph1_tick)
      insn_valid <= !flush;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_taken <= 1'h0;
    else
      irq_taken <= next_irq_taken;
  end

  // data memory strobes registered from the phase two and four ticks, high one clock later
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      operand_rd <= 1'h0;
    else
      operand_rd <= next_operand_rd;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      dest_wr <= 1'h0;
    else
      dest_wr <= next_dest_wr;
  end

  // fetch address is the counter; 13 bits reach all 8k words
  assign o_prog_addr = pc;
  assign o_insn = insn;
  assign o_insn_valid = insn_valid;
  assign o_operand_read = operand_rd;
  assign o_dest_write = dest_wr;
  assign o_irq_taken = irq_taken;
  assign o_phase = phase;
  assign o_cycle_out = i_cycle_out_en && cyc_raw;
endmodule
`default_nettype wire

// file: ics_sva.sv
// Purpose: port checks for the sequencer
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module ics_sva
  import ics_pkg::*;
(
  // in
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cycle_out_en,
  input wire logic i_jump,
  input wire logic i_irq,
  // out
  input wire logic o_cycle_out,
  input wire logic [12:0] o_prog_addr,
  input wire logic [13:0] o_insn,
  input wire logic o_insn_valid,
  input wire logic o_operand_read,
  input wire logic o_dest_write,
  input wire logic o_irq_taken,
  input wire logic [1:0] o_phase
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_ph;
    $changed(o_phase) |-> o_phase == {$past(o_phase[0]), !$past(o_phase[1])};
  endproperty
  a_ph: assert property (p_ph) else $error("phase order broken");
  property p_co;
    o_cycle_out == (i_cycle_out_en && o_phase[1]);
  endproperty
  a_co: assert property (p_co) else $error("cycle out wrong");
  property p_rd;
    o_operand_read == ($past(o_phase) == 2'h1 && o_phase == 2'h3 &&
      $past(o_insn_valid));
  endproperty
  a_rd: assert property (p_rd) else $error("operand read wrong");
  property p_wr;
    o_dest_write == ($past(o_phase) == 2'h2 && o_phase == 2'h0 &&
      $past(o_insn_valid));
  endproperty
  a_wr: assert property (p_wr) else $error("dest write wrong");
  property p_pc;
    $changed(o_prog_addr) && !$past(i_jump) && !$past(i_irq) |->
      $past(o_phase) == 2'h0 && o_prog_addr == $past(o_prog_addr) + 13'h1;
  endproperty
  a_pc: assert property (p_pc) else $error("pc step wrong");
  property p_iv; o_irq_taken |-> o_prog_addr == IRQ_VECTOR; endproperty
  a_iv: assert property (p_iv) else $error("irq vector wrong");
  property p_nop; !o_insn_valid |-> o_insn == NOP_WORD; endproperty
  a_nop: assert property (p_nop) else $error("squash not nop");
  property p_rst;
    $fell(i_rst) |-> o_prog_addr == RESET_VECTOR && o_phase == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind ics_sequencer ics_sva ics_sva_inst
(
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_cycle_out_en(i_cycle_out_en),
  .i_jump(i_jump),
  .i_irq(i_irq),
  .o_cycle_out(o_cycle_out),
  .o_prog_addr(o_prog_addr),
  .o_insn(o_insn),
  .o_insn_valid(o_insn_valid),
  .o_operand_read(o_operand_read),
  .o_dest_write(o_dest_write),
  .o_irq_taken(o_irq_taken),
  .o_phase(o_phase)
);
`default_nettype wire

// file: ics_pmem.sv
// Purpose: program memory model
// Assumes: combinational read
// Notes: word holds its own address
`timescale 1ns/1ps
`default_nettype none
module ics_pmem
(
  // port
  input wire logic [12:0] i_addr,
  output logic [13:0] o_data
);
  assign o_data = {1'h1, i_addr};
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking sequencer bench
// Assumes: word model holds its address
// Notes: model tracks next executed address
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ics_pkg::*;
  logic i_clk = 0, i_rst = 1, i_use_pll = 0, i_clk_tick = 0, dw = 0, it = 0;
  logic i_cycle_out_en = 0, i_jump = 0, i_irq = 0, o_cycle_out, o_irq_taken;
  logic [12:0] i_jump_target = 0, o_prog_addr, pa;
  logic [13:0] i_prog_data, o_insn, ins;
  logic o_insn_valid, o_operand_read, o_dest_write;
  logic [1:0] o_phase;
  int miscompares = 0, total_checks = 0, seed = 65384;
  int ex = 0, n = 0, c = 0, l = 0, m = 0, pm = 0, r = 0, nrd = 0;
  ics_sequencer ics_sequencer_inst
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_use_pll(i_use_pll),
    .i_clk_tick(i_clk_tick),
    .i_cycle_out_en(i_cycle_out_en),
    .o_cycle_out(o_cycle_out),
    .o_prog_addr(o_prog_addr),
    .i_prog_data(i_prog_data),
    .i_jump(i_jump),
    .i_jump_target(i_jump_target),
    .i_irq(i_irq),
    .o_insn(o_insn),
    .o_insn_valid(o_insn_valid),
    .o_operand_read(o_operand_read),
    .o_dest_write(o_dest_write),
    .o_irq_taken(o_irq_taken),
    .o_phase(o_phase)
  );
  ics_pmem ics_pmem_inst (.i_addr(o_prog_addr), .o_data(i_prog_data));
  task automatic chk(string s, logic [13:0] e, logic [13:0] v);
    total_checks++;
    if (v !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %0h got %0h", s, e, v);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial forever #50 i_clk = ~i_clk;
  initial
  begin
    #300000;
    miscompares++;
    wrap_up;
  end
  always @(negedge i_clk)
  begin
    dw <= o_dest_write;
    ins <= o_insn;
    pa <= o_prog_addr;
    it <= o_irq_taken;
    nrd <= nrd + o_operand_read;
  end
  always @(posedge i_clk)
  begin
    c <= c + 1;
    i_clk_tick <= m == 2 ? 1'($random(seed)) : m == 0 || c % 4 == 0;
    i_cycle_out_en <= 1'($random(seed));
    if (dw)
    begin
      chk("insn", {1'h1, ex[12:0]}, ins);
      chk("reads", 14'(n + 1), 14'(nrd));
      chk("irq taken", 14'(i_irq), 14'(it));
      if (m < 2 && m == pm && l > 0)
        chk("gap", r ? 14'h8 : 14'h4, 14'(c - l));
      r = i_jump || i_irq;
      ex = i_irq ? 4 : i_jump ? i_jump_target : (ex + 1) % 8192;
      chk("next pc", 14'(ex), 14'(pa));
      l = c;
      pm = m;
      n++;
      i_jump <= $random(seed) % 4 == 0;
      i_irq <= $random(seed) % 16 == 0;
      i_jump_target <= 13'($random(seed));
    end
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_rst <= 0;
    @(negedge i_clk);
    chk("pc", 14'(RESET_VECTOR), 14'(o_prog_addr));
    chk("vld", 14'h0, 14'(o_insn_valid));
    repeat (400) @(posedge i_clk);
    $display("direct test done");
    i_use_pll <= 1;
    m <= 1;
    repeat (400) @(posedge i_clk);
    $display("pll test done");
    i_use_pll <= 0;
    m <= 2;
    repeat (400) @(posedge i_clk);
    chk("ran", 14'h1, 14'(n > 150));
    $display("random tick test done");
    wrap_up;
  end
endmodule
`default_nettype wire
